/* tb/rep_arb_model.sv */
/*
  Expansion arbiter with one peer repeater behind it.
  Assumes the bench resolves the shared pins from the enables.
*/
`timescale 1ns/10ps
module rep_arb_model (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic req_n,
  input wire logic peer_act,
  input wire logic hold,
  output logic ack_n,
  output logic col_n,
  output logic peer_oe
);
  logic ack_d;
  logic col_d;
  // Hold stalls every grant so the device queue can fill up
  always_comb begin
    ack_d = !(!hold && (!req_n || peer_act));
    col_d = !(!req_n && peer_act);
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ack_n <= 1'h1;
      col_n <= 1'h1;
    end else begin
      ack_n <= ack_d;
      col_n <= col_d;
    end
  end
  // Peer drives only while granted and the device is not requesting
  assign peer_oe = peer_act && !ack_n && req_n;
endmodule // rep_arb_model

/* tb/rep_xport_asserts.sv */
/*
  Port assertions for the expansion port.
  Assumes it is bound to every rep_xport instance.
*/
`timescale 1ns/10ps
module rep_xport_asserts
  import rep_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [NUM_PORTS-1:0] port_carrier,
  input wire logic req_n,
  input wire logic ack_n,
  input wire logic col_n,
  input wire logic expansion_data_line_i,
  input wire logic expansion_data_line_oe,
  input wire logic jam_i,
  input wire logic jam_oe,
  input wire logic rx_valid,
  input wire logic rx_data,
  input wire logic rx_jam,
  input wire logic jam_gen,
  input wire logic carrier_status_serial,
  input wire logic status_strobe,
  input wire logic status_strobe_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_req_active: assert property ((|port_carrier) |=> !req_n)
    else $error("request not low while carrier present");
  a_grant_drive: assert property ((!req_n && !ack_n && |port_carrier) |=> expansion_data_line_oe && jam_oe)
    else $error("granted requester not driving");
  a_drive_needs: assert property (expansion_data_line_oe |-> !req_n && !$past(ack_n))
    else $error("shared lines driven without request and grant");
  a_rx_sample: assert property (rx_valid |-> $past(req_n) && rx_data == $past(expansion_data_line_i)
    && rx_jam == $past(jam_i))
    else $error("listen sample wrong");
  a_jam_on_col: assert property ((!col_n && |port_carrier) |-> ##[0:2] jam_gen)
    else $error("no jam on expansion collision");
  a_crs_rate: assert property ($changed(carrier_status_serial) |=> $stable(carrier_status_serial)[*4])
    else $error("carrier bit shorter than a crystal tick");
  a_strobe_rise: assert property ($rose(status_strobe) |-> status_strobe[*8])
    else $error("strobe too short");
  a_strobe_fall: assert property ($fell(status_strobe) |-> $past(status_strobe, 10) && !$past(status_strobe, 11))
    else $error("strobe not two ticks long");
  a_strobe_oe: assert property (status_strobe |-> status_strobe_oe)
    else $error("strobe high while pin is an input");
endmodule // rep_xport_asserts
bind rep_xport rep_xport_asserts chk_u (.core_clk, .nrst, .port_carrier, .req_n, .ack_n, .col_n,
  .expansion_data_line_i, .expansion_data_line_oe, .jam_i, .jam_oe, .rx_valid, .rx_data, .rx_jam,
  .jam_gen, .carrier_status_serial, .status_strobe, .status_strobe_oe);

/* tb/testbench.sv */
/*
  Self-checking bench for the expansion port.
  Assumes rep_arb_model as arbiter and peer; shared lines pulled up.
*/
`timescale 1ns/10ps
module testbench;
  import rep_pkg::*;
  logic core_clk = '0, nrst = '0, tx_busy = '0, src_valid = '0, strobe_out_en = '0;
  logic [NUM_PORTS-1:0] port_carrier = '0, port_collision = '0;
  logic [FIFO_WIDTH-1:0] src_data = '0;
  logic peer_act = '0, hold = '0, peer_d = '0, peer_j = '0, peer_oe;
  logic src_ready, req_n, ack_n, col_n, expansion_data_line_o, expansion_data_line_oe, jam_o, jam_oe;
  logic rx_valid, rx_data, rx_jam, jam_gen, carrier_status_serial, status_strobe, status_strobe_oe;
  int errors = 0, samples_checked = 0, cycles = 0;
  wire data_w = expansion_data_line_oe ? expansion_data_line_o : peer_oe ? peer_d : 1'h1;
  wire jam_w = jam_oe ? jam_o : peer_oe ? peer_j : 1'h1;
  rep_xport dut_u (.*, .expansion_data_line_i(data_w), .jam_i(jam_w));
  rep_arb_model arb_u (.core_clk, .nrst, .req_n, .peer_act, .hold, .ack_n, .col_n, .peer_oe);
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      test_done();
    end
  end
  ////////////////////////////////////////
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wait_for(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 200) begin
      cyc(1);
      n++;
    end
    chk(s, v);
  endtask
  task automatic test_done;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic t_stream;
    logic [8:0] pat;
    pat = 9'h1_a5;
    port_carrier = pat;
    strobe_out_en = 1'h1;
    hold = 1'h1;
    cyc(100);
    @(posedge status_strobe);
    cyc(3);
    for (int i = 0; i < 18; i++) begin
      chk(carrier_status_serial, pat[i % 9]);
      chk(status_strobe, (i % 9) < 2);
      cyc(5);
    end
    chk(req_n, 1'h0);
    chk(status_strobe_oe, 1'h1);
    port_carrier = '0;
  endtask
  task automatic t_fifo;
    logic [7:0] bits;
    bits = 8'h4d;
    for (int i = 0; i < 9; i++) begin
      src_valid = 1'h1;
      src_data = (i < 8) ? bits[i] : 1'h1;
      cyc(1);
    end
    src_valid = 1'h0;
    cyc(2);
    chk(src_ready, 1'h0);
    chk(req_n, 1'h0);
    hold = 1'h0;
    wait_for(expansion_data_line_oe, 1'h1);
    wait_for(expansion_data_line_o, 1'h1);
    cyc(2);
    for (int i = 0; i < 9; i++) begin
      // Ninth slot: queue drained, both lines released to the pull-up
      chk({jam_w, data_w}, (i < 8) ? {1'h0, bits[i]} : 2'h3);
      cyc(5);
    end
    wait_for(req_n, 1'h1);
    cyc(2);
    chk(expansion_data_line_oe, 1'h0);
  endtask
  task automatic t_collision;
    port_carrier = 9'h0_003;
    port_collision = 9'h0_003;
    wait_for(jam_o, 1'h1);
    cyc(2);
    chk({jam_w, data_w}, 2'h2);
    port_collision = 9'h0_010;
    cyc(6);
    chk({jam_w, data_w}, 2'h3);
    peer_act = 1'h1;
    cyc(3);
    chk({col_n, jam_gen}, 2'h1);
    port_collision = '0;
    port_carrier = '0;
    peer_act = 1'h0;
    cyc(10);
  endtask
  task automatic t_listen;
    peer_act = 1'h1;
    for (int k = 0; k < 4; k++) begin
      peer_d = k[0];
      peer_j = k[1];
      cyc(6);
      wait_for(rx_valid, 1'h1);
      chk({rx_jam, rx_data}, k[1:0]);
      chk(expansion_data_line_oe, 1'h0);
    end
    tx_busy = 1'h1;
    cyc(3);
    chk(req_n, 1'h0);
    tx_busy = 1'h0;
    peer_act = 1'h0;
    cyc(10);
  endtask
  initial begin
    repeat (16) @(negedge core_clk);
    nrst = 1'h1;
    cyc(2);
    chk({req_n, expansion_data_line_oe, jam_oe}, 3'h4);
    chk({status_strobe, status_strobe_oe}, 2'h0);
    t_stream();
    t_fifo();
    t_collision();
    t_listen();
    test_done();
  end
endmodule // testbench

/* verilog/rep_fifo.sv */
/*
  Small flip-flop FIFO with valid/ready on both sides.
  Assumes one clock; push and pop may happen in the same cycle.
*/
`timescale 1ns/10ps
module rep_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] CNT_FULL = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready = (cnt_q != CNT_FULL);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];

  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_data;
      wr_d = (wr_q == PTR_LAST) ? '0 : wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = (rd_q == PTR_LAST) ? '0 : rd_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      mem_q <= mem_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end
endmodule // rep_fifo

/* verilog/rep_pkg.sv */
/*
  Shared constants and types for the repeater expansion port.
  Assumes a single 100 MHz core clock and a 20 MHz crystal-rate enable derived from it.
*/
package rep_pkg;
  localparam int CORE_CLK_HZ = 100_000_000;
  localparam int CRYSTAL_HZ = 20_000_000;
  localparam int TICK_DIV = CORE_CLK_HZ / CRYSTAL_HZ;
  localparam logic [2:0] TICK_LAST = 3'(TICK_DIV - 1);
  localparam logic [2:0] TICK_ZERO = 3'h0;

  // Carrier frame: bit 0 is the AUI port, bits 1..8 are twisted-pair ports 0..7
  localparam int NUM_PORTS = 9;
  localparam logic [3:0] FRAME_LAST = 4'h8;
  localparam logic [3:0] FRAME_ZERO = 4'h0;
  localparam logic [1:0] STROBE_TICKS = 2'h2;
  localparam logic [1:0] STROBE_ZERO = 2'h0;

  localparam int FIFO_WIDTH = 1;
  localparam int FIFO_DEPTH = 8;

  // Idle level of expansion data when nothing is queued
  localparam logic DATA_IDLE = 1'b0;
  // Collision code on the data line while the jam flag is high
  localparam logic CODE_MULTI = 1'b0;
  localparam logic CODE_SINGLE = 1'b1;

  typedef enum logic [1:0] {
    REP_IDLE = 2'h0,
    REP_REQ = 2'h1,
    REP_OWN = 2'h3,
    REP_LISTEN = 2'h2
  } rep_xstate_t;

  function automatic logic [3:0] rep_count_ones(input logic [NUM_PORTS-1:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < NUM_PORTS; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction
endpackage

/* verilog/rep_xport.sv */
/*
  Repeater expansion port: request/grant arbitration of the shared data and jam lines,
  collision signalling, and the serial carrier-status stream with its strobe.
  Assumes all inputs are synchronous to core_clk and the pad logic resolves the
  three-state lines from the output enables.
*/
// Functional notes
// RL1 - Once the grant input is low while requesting, the device drives the shared data and jam lines.
// RL2 - With the grant low and no request, the device samples the jam and data lines as valid status and data.
// RL3 - A low expansion collision input makes the device raise its own jam sequence without coordinating; jam_gen: !col_n while active, or 2+ ports colliding.
// RL4 - Carrier-sense states of the AUI and eight twisted-pair ports are shifted out continuously at crystal rate.
// RL5 - The request output is driven low while any port receives or collides or the transmit queue is busy.
// RL6 - Data and jam pins float without grant, drive with grant and request, and are inputs with grant only.
// RL7 - Outside collision NRZ data is driven; with the jam flag high data shows 0 for multiport, 1 for single.
// RL8 - When used as an output the strobe goes high for two crystal cycles after each group of nine bits.
// RL9 - Each frame sends AUI first then twisted-pair ports 0 to 7, frames back to back without idle bits.
`timescale 1ns/10ps
module rep_xport
  import rep_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [NUM_PORTS-1:0] port_carrier,
  input wire logic [NUM_PORTS-1:0] port_collision,
  input wire logic tx_busy,
  input wire logic src_valid,
  input wire logic [FIFO_WIDTH-1:0] src_data,
  output logic src_ready,
  output logic req_n,
  input wire logic ack_n,
  input wire logic col_n,
  input wire logic expansion_data_line_i,
  output logic expansion_data_line_o,
  output logic expansion_data_line_oe,
  input wire logic jam_i,
  output logic jam_o,
  output logic jam_oe,
  output logic rx_valid,
  output logic rx_data,
  output logic rx_jam,
  output logic jam_gen,
  output logic carrier_status_serial,
  input wire logic strobe_out_en,
  output logic status_strobe,
  output logic status_strobe_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Crystal-rate enable

  logic [2:0] div_q, div_d;
  logic tick_q, tick_d;

  always_comb begin
    div_d = (div_q == TICK_LAST) ? TICK_ZERO : div_q + 3'h1;
    tick_d = (div_q == TICK_LAST);
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div_q <= TICK_ZERO;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit queue

  logic q_valid, q_pop;
  logic [FIFO_WIDTH-1:0] q_data;
  logic src_ready_w;

  rep_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .nrst(nrst),
    .in_valid(src_valid),
    .in_data(src_data),
    .in_ready(src_ready_w),
    .out_valid(q_valid),
    .out_data(q_data),
    .out_ready(q_pop)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration and shared lines

  rep_xstate_t st_q, st_d;
  logic active;
  logic own_coll;
  logic req_n_q, req_n_d;
  logic drv_q, drv_d;
  logic xd_q, xd_d;
  logic tail_q, tail_d;
  logic jam_q, jam_d;
  logic rxv_q, rxv_d, rxd_q, rxd_d, rxj_q, rxj_d;
  logic jg_q, jg_d;
  logic srdy_q, srdy_d;

  always_comb begin
    active = (|port_carrier) || (|port_collision) || tx_busy || q_valid || tail_q; // RL5
    own_coll = (|port_collision);
    st_d = st_q;
    unique case (st_q)
      REP_IDLE: begin
        if (active) begin
          st_d = REP_REQ;
        end else if (!ack_n) begin
          st_d = REP_LISTEN;
        end
      end
      REP_REQ: begin
        if (!active) begin
          st_d = REP_IDLE;
        end else if (!ack_n) begin
          st_d = REP_OWN; // RL1
        end
      end
      REP_OWN: begin
        if (!active) begin
          st_d = REP_IDLE;
        end else if (ack_n) begin
          st_d = REP_REQ;
        end
      end
      REP_LISTEN: begin
        if (active) begin
          st_d = REP_REQ;
        end else if (ack_n) begin
          st_d = REP_IDLE;
        end
      end
    endcase
    req_n_d = !((st_d == REP_REQ) || (st_d == REP_OWN)); // RL5
    // Pins drive only while granted and requesting, else they float or listen
    drv_d = (st_d == REP_OWN); // RL6
    q_pop = tick_q && (st_q == REP_OWN) && !own_coll;
    xd_d = xd_q;
    jam_d = jam_q;
    if (tick_q && (st_q == REP_OWN)) begin
      if (own_coll) begin
        jam_d = 1'b1; // RL7
        xd_d = (rep_count_ones(port_collision) > 4'h1) ? CODE_MULTI : CODE_SINGLE; // RL7
      end else begin
        jam_d = 1'b0;
        xd_d = q_valid ? q_data[0] : DATA_IDLE; // RL7
      end
    end
    // Last popped bit must stand a whole bit time before the request drops
    tail_d = (q_pop && q_valid) ? 1'b1 : (tick_q ? 1'b0 : tail_q); // RL5
    rxv_d = tick_q && (st_q == REP_LISTEN); // RL2
    rxd_d = rxv_d ? expansion_data_line_i : rxd_q; // RL2
    rxj_d = rxv_d ? jam_i : rxj_q; // RL2
    // Each device jams on its own; no handshake with peers is needed
    jg_d = (!col_n && active) || (rep_count_ones(port_collision) > 4'h1); // RL3
    srdy_d = src_ready_w;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= REP_IDLE;
      req_n_q <= 1'b1;
      drv_q <= 1'b0;
      xd_q <= DATA_IDLE;
      tail_q <= 1'b0;
      jam_q <= 1'b0;
      rxv_q <= 1'b0;
      rxd_q <= 1'b0;
      rxj_q <= 1'b0;
      jg_q <= 1'b0;
      srdy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      req_n_q <= req_n_d;
      drv_q <= drv_d;
      xd_q <= xd_d;
      tail_q <= tail_d;
      jam_q <= jam_d;
      rxv_q <= rxv_d;
      rxd_q <= rxd_d;
      rxj_q <= rxj_d;
      jg_q <= jg_d;
      srdy_q <= srdy_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Carrier-status stream

  logic [NUM_PORTS-1:0] latch_q, latch_d;
  logic [NUM_PORTS-1:0] shift_q, shift_d;
  logic [3:0] bit_q, bit_d;
  logic [1:0] stb_q, stb_d;
  logic cs_bit_q, cs_bit_d;
  logic frame_done_q, frame_done_d;
  logic stro_q, stro_d;
  logic stoe_q, stoe_d;

  always_comb begin
    // Sticky latch so a short carrier between samples is not missed; new carrier wins over clear
    latch_d = latch_q | port_carrier;
    shift_d = shift_q;
    bit_d = bit_q;
    stb_d = stb_q;
    cs_bit_d = cs_bit_q;
    if (tick_q) begin
      if (bit_q == FRAME_ZERO) begin
        cs_bit_d = latch_q[0]; // RL9
        shift_d = {1'b0, latch_q[NUM_PORTS-1:1]};
        latch_d = port_carrier;
      end else begin
        cs_bit_d = shift_q[0]; // RL4
        shift_d = {1'b0, shift_q[NUM_PORTS-1:1]};
      end
      bit_d = (bit_q == FRAME_LAST) ? FRAME_ZERO : bit_q + 4'h1; // RL9
      if (bit_q == FRAME_ZERO && frame_done_q) begin
        stb_d = STROBE_TICKS; // RL8
      end else if (stb_q != STROBE_ZERO) begin
        stb_d = stb_q - 2'h1;
      end
    end
    stro_d = strobe_out_en && (stb_d != STROBE_ZERO); // RL8
    stoe_d = strobe_out_en;
  end

  // A strobe arms at the first bit of each frame after the previous nine have gone out
  always_comb begin
    frame_done_d = frame_done_q;
    if (tick_q && bit_q == FRAME_LAST) begin
      frame_done_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      latch_q <= '0;
      shift_q <= '0;
      bit_q <= FRAME_ZERO;
      stb_q <= STROBE_ZERO;
      cs_bit_q <= 1'b0;
      stro_q <= 1'b0;
      stoe_q <= 1'b0;
      frame_done_q <= 1'b0;
    end else begin
      latch_q <= latch_d;
      shift_q <= shift_d;
      bit_q <= bit_d;
      stb_q <= stb_d;
      cs_bit_q <= cs_bit_d;
      stro_q <= stro_d;
      stoe_q <= stoe_d;
      frame_done_q <= frame_done_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign src_ready = srdy_q;
  assign req_n = req_n_q;
  assign expansion_data_line_o = xd_q;
  assign expansion_data_line_oe = drv_q;
  assign jam_o = jam_q;
  assign jam_oe = drv_q;
  assign rx_valid = rxv_q;
  assign rx_data = rxd_q;
  assign rx_jam = rxj_q;
  assign jam_gen = jg_q;
  assign carrier_status_serial = cs_bit_q;
  assign status_strobe = stro_q;
  assign status_strobe_oe = stoe_q;
endmodule // rep_xport
